// File: design/liugc_pkg.sv
// Purpose: Constants for the line interface global configuration bank
// Assumes: Avalon-MM word addressing, one register per 32-bit word
// Notes: Register index equals the printed byte offset of the part
package liugc_pkg;
	localparam int LIUGC_CH = 8;
	localparam int LIUGC_AW = 8;
	// Register indices
	localparam logic [7:0] LIUGC_CLK_LOS = 8'h81;
	localparam logic [7:0] LIUGC_TX_TERM = 8'h82;
	localparam logic [7:0] LIUGC_VSEL = 8'h8C;
	localparam logic [7:0] LIUGC_CCTRL = 8'h8D;
	localparam logic [7:0] LIUGC_CDATA = 8'h8E;
	localparam logic [7:0] LIUGC_IRQ_STAT = 8'h90;
	localparam logic [7:0] LIUGC_IRQ_MASK = 8'h91;
	localparam logic [7:0] LIUGC_HOST_GLB = 8'h92;
	localparam logic [7:0] LIUGC_CH_TRANSMITTER_ON = 8'h93;
	localparam logic [7:0] LIUGC_CH_TERM = 8'h94;
	// Field positions, clock/loss/test register
	localparam int LIUGC_B_SYN_HI = 5;
	localparam int LIUGC_B_SYN_LO = 4;
	localparam int LIUGC_B_RATE = 3;
	localparam int LIUGC_B_MUTE = 2;
	localparam int LIUGC_B_EXLOSS = 1;
	localparam int LIUGC_B_ICT = 0;
	// Field positions, transmit/termination register
	localparam int LIUGC_B_TXSRC = 7;
	localparam int LIUGC_B_TERMSRC = 6;
	// Field positions, counter control register
	localparam int LIUGC_B_ALLCLR = 4;
	localparam int LIUGC_B_ALLLAT = 3;
	localparam int LIUGC_B_BYTE = 2;
	localparam int LIUGC_B_CHLAT = 1;
	localparam int LIUGC_B_CHCLR = 0;
	// Field positions, host global register
	localparam int LIUGC_B_GTXON = 0;
	localparam int LIUGC_B_GTERM = 1;
	// Reset values and selector codes
	localparam logic [7:0] LIUGC_RST8 = 8'h00;
	localparam logic [15:0] LIUGC_RST16 = 16'h0000;
	localparam logic [3:0] LIUGC_SEL_NONE = 4'h0;
	localparam logic [3:0] LIUGC_SEL_LAST = 4'h8;
	// Loss-of-signal zero thresholds, in received bits, and the violation counter ceiling
	localparam logic [12:0] LIUGC_LOS_EXT = 13'h1000;
	localparam logic [12:0] LIUGC_LOS_T1 = 13'h00AF;
	localparam logic [12:0] LIUGC_LOS_E1 = 13'h0020;
	localparam logic [15:0] LIUGC_CNT_MAX = 16'hFFFF;
endpackage

// File: design/liugc_regs.sv
// Purpose: Global configuration registers and violation counters, eight channels
// Assumes: All inputs synchronous to mclk_i; rx_bit_en_i marks each received bit
// Notes: Avalon-MM slave answers every access in one wait cycle
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module liugc_regs
	import liugc_pkg::*;
(
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic [LIUGC_AW-1:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] writedata_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	output logic irq_o,
	input wire logic host_mode_i,
	input wire logic in_circuit_test_n_i,
	input wire logic transmitter_on_pin_i,
	input wire logic receive_termination_pin_i,
	input wire logic [LIUGC_CH-1:0] rx_bit_en_i,
	input wire logic [LIUGC_CH-1:0] rx_pos_in_i,
	input wire logic [LIUGC_CH-1:0] rx_neg_in_i,
	input wire logic [LIUGC_CH-1:0] line_code_violation_i,
	output logic [LIUGC_CH-1:0] receive_positive_data_o,
	output logic [LIUGC_CH-1:0] receive_negative_data_o,
	output logic [LIUGC_CH-1:0] receive_signal_loss_o,
	output logic [LIUGC_CH-1:0] transmitter_on_o,
	output logic [LIUGC_CH-1:0] receive_termination_select_o,
	output logic master_rate_select_o,
	output logic synth_input_select_hi_o,
	output logic synth_input_select_lo_o,
	output logic outputs_float_o
);
	logic [7:0] clk_los_test;
	logic [1:0] tx_term_ctrl;
	logic [3:0] chan_sel;
	logic [4:0] cnt_ctrl;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic [1:0] host_glb;
	logic [7:0] ch_transmitter_on;
	logic [7:0] ch_term;
	logic [15:0] vcount [LIUGC_CH];
	logic [15:0] vhold [LIUGC_CH];
	logic [12:0] zero_run [LIUGC_CH];
	logic [LIUGC_CH-1:0] loss;
	logic [LIUGC_CH-1:0] loss_rise;
	logic [LIUGC_CH-1:0] ch_hit;
	logic [12:0] los_limit;
	logic wr_go;
	logic [7:0] wbyte;
	logic latch_all;
	logic latch_one;
	logic [15:0] sel_hold;
	logic [7:0] cdata;
	logic [31:0] next_readdata;
	logic glb_tx;
	logic glb_term;

	// A write lands only on the edge where the master sees waitrequest low
	assign wr_go = write_i && !waitrequest_o;
	assign wbyte = writedata_i[7:0];

	// Bus handshake: one wait cycle, then a single ready cycle
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			waitrequest_o <= 1'b1;
		end else if ((read_i || write_i) && waitrequest_o) begin
			waitrequest_o <= 1'b0;
		end else begin
			waitrequest_o <= 1'b1;
		end
	end

	// Clock, loss and test register; bits above the synth selects read zero
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			clk_los_test <= LIUGC_RST8;
		end else if (wr_go && address_i == LIUGC_CLK_LOS) begin
			clk_los_test <= {2'h0, wbyte[5:0]};
		end
	end

	// Transmit and termination source register; low six bits unused
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_term_ctrl <= 2'h0;
		end else if (wr_go && address_i == LIUGC_TX_TERM) begin
			tx_term_ctrl <= {wbyte[LIUGC_B_TXSRC], wbyte[LIUGC_B_TERMSRC]};
		end
	end

	// Selector keeps only its low nibble
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			chan_sel <= LIUGC_SEL_NONE;
		end else if (wr_go && address_i == LIUGC_VSEL) begin
			chan_sel <= wbyte[3:0];
		end
	end

	// Counter control bits are plain levels; latches act on the write itself
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_ctrl <= 5'h00;
		end else if (wr_go && address_i == LIUGC_CCTRL) begin
			cnt_ctrl <= wbyte[4:0];
		end
	end

	// Host-mode globals and per-channel enables
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			host_glb <= 2'h0;
			ch_transmitter_on <= LIUGC_RST8;
			ch_term <= LIUGC_RST8;
		end else if (wr_go) begin
			if (address_i == LIUGC_HOST_GLB) begin
				host_glb <= wbyte[1:0];
			end
			if (address_i == LIUGC_CH_TRANSMITTER_ON) begin
				ch_transmitter_on <= wbyte;
			end
			if (address_i == LIUGC_CH_TERM) begin
				ch_term <= wbyte;
			end
		end
	end

	// Interrupt mask
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_mask <= LIUGC_RST8;
		end else if (wr_go && address_i == LIUGC_IRQ_MASK) begin
			irq_mask <= wbyte;
		end
	end

	// Sticky loss-onset flags; a new onset beats a same-cycle clear
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_status <= LIUGC_RST8;
		end else if (wr_go && address_i == LIUGC_IRQ_STAT) begin
			irq_status <= (irq_status & ~wbyte) | loss_rise;
		end else begin
			irq_status <= irq_status | loss_rise;
		end
	end

	// Level interrupt, registered
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_status & irq_mask);
		end
	end

	// Zero threshold: extended overrides the rate-specific figure
	assign los_limit = clk_los_test[LIUGC_B_EXLOSS] ? LIUGC_LOS_EXT :
		(clk_los_test[LIUGC_B_RATE] ? LIUGC_LOS_T1 : LIUGC_LOS_E1);
	assign latch_all = wr_go && address_i == LIUGC_CCTRL && wbyte[LIUGC_B_ALLLAT];
	assign latch_one = wr_go && address_i == LIUGC_CCTRL && wbyte[LIUGC_B_CHLAT];
	assign glb_tx = host_mode_i ? host_glb[LIUGC_B_GTXON] : transmitter_on_pin_i;
	assign glb_term = host_mode_i ? host_glb[LIUGC_B_GTERM] : receive_termination_pin_i;

	// Per-channel counters, loss detection and output steering
	genvar g;
	generate
		for (g = 0; g < LIUGC_CH; g++) begin : gch
			// Selector code g+1 addresses channel g; code zero hits none
			assign ch_hit[g] = (chan_sel == 4'(g + 1));
			assign loss_rise[g] = !loss[g] && rx_bit_en_i[g] && !rx_pos_in_i[g]
				&& !rx_neg_in_i[g] && (zero_run[g] + 13'h0001 >= los_limit);

			// Violation count held at zero while the all-clear bit, or the channel clear bit with this channel selected, stands
			always_ff @(posedge mclk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					vcount[g] <= LIUGC_RST16;
				end else if (cnt_ctrl[LIUGC_B_ALLCLR]
					|| (cnt_ctrl[LIUGC_B_CHCLR] && ch_hit[g])) begin
					vcount[g] <= LIUGC_RST16;
				end else if (line_code_violation_i[g] && vcount[g] != LIUGC_CNT_MAX) begin
					vcount[g] <= vcount[g] + 16'h0001;
				end
			end

			// Holding register keeps a stable snapshot for byte reads
			always_ff @(posedge mclk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					vhold[g] <= LIUGC_RST16;
				end else if (latch_all || (latch_one && ch_hit[g])) begin
					vhold[g] <= vcount[g];
				end
			end

			// Run of zeros; any mark ends the run and the loss
			always_ff @(posedge mclk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					zero_run[g] <= 13'h0000;
					loss[g] <= 1'b0;
				end else if (rx_bit_en_i[g]) begin
					if (rx_pos_in_i[g] || rx_neg_in_i[g]) begin
						zero_run[g] <= 13'h0000;
						loss[g] <= 1'b0;
					end else if (!loss[g]) begin
						zero_run[g] <= zero_run[g] + 13'h0001;
						loss[g] <= loss_rise[g];
					end
				end
			end

			// Registered line outputs
			always_ff @(posedge mclk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					receive_positive_data_o[g] <= 1'b0;
					receive_negative_data_o[g] <= 1'b0;
					receive_signal_loss_o[g] <= 1'b0;
					transmitter_on_o[g] <= 1'b0;
					receive_termination_select_o[g] <= 1'b0;
				end else begin
					receive_signal_loss_o[g] <= loss[g];
					if (clk_los_test[LIUGC_B_MUTE] && loss[g]) begin
						receive_positive_data_o[g] <= 1'b0;
						receive_negative_data_o[g] <= 1'b0;
					end else begin
						receive_positive_data_o[g] <= rx_pos_in_i[g];
						receive_negative_data_o[g] <= rx_neg_in_i[g];
					end
					transmitter_on_o[g] <= tx_term_ctrl[1] ? ch_transmitter_on[g] : glb_tx;
					receive_termination_select_o[g] <= tx_term_ctrl[0] ?
						receive_termination_pin_i : (glb_term & ch_term[g]);
				end
			end
		end
	endgenerate

	// Selected snapshot; no channel reads as zero
	always_comb begin
		sel_hold = LIUGC_RST16;
		if (chan_sel != LIUGC_SEL_NONE && chan_sel <= LIUGC_SEL_LAST) begin
			sel_hold = vhold[3'(chan_sel - 4'h1)];
		end
		cdata = cnt_ctrl[LIUGC_B_BYTE] ? sel_hold[15:8] : sel_hold[7:0];
	end

	// Read multiplexer; unmapped words read zero
	always_comb begin
		next_readdata = 32'h0000_0000;
		unique case (address_i)
			LIUGC_CLK_LOS: next_readdata[7:0] = clk_los_test;
			LIUGC_TX_TERM: next_readdata[7:6] = tx_term_ctrl;
			LIUGC_VSEL: next_readdata[3:0] = chan_sel;
			LIUGC_CCTRL: next_readdata[4:0] = cnt_ctrl;
			LIUGC_CDATA: next_readdata[7:0] = cdata;
			LIUGC_IRQ_STAT: next_readdata[7:0] = irq_status;
			LIUGC_IRQ_MASK: next_readdata[7:0] = irq_mask;
			LIUGC_HOST_GLB: next_readdata[1:0] = host_glb;
			LIUGC_CH_TRANSMITTER_ON: next_readdata[7:0] = ch_transmitter_on;
			LIUGC_CH_TERM: next_readdata[7:0] = ch_term;
			default: next_readdata = 32'h0000_0000;
		endcase
	end

	// Read data captured in the wait cycle, stands through the ready cycle
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			readdata_o <= 32'h0000_0000;
		end else if (read_i && waitrequest_o) begin
			readdata_o <= next_readdata;
		end
	end

	// Global strap-like outputs, all registered
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			master_rate_select_o <= 1'b0;
			synth_input_select_hi_o <= 1'b0;
			synth_input_select_lo_o <= 1'b0;
			outputs_float_o <= 1'b0;
		end else begin
			master_rate_select_o <= clk_los_test[LIUGC_B_RATE];
			synth_input_select_hi_o <= clk_los_test[LIUGC_B_SYN_HI];
			synth_input_select_lo_o <= clk_los_test[LIUGC_B_SYN_LO];
			// Register bit and grounded pin act alike
			outputs_float_o <= clk_los_test[LIUGC_B_ICT] || !in_circuit_test_n_i;
		end
	end
endmodule

// File: testbench/liugc_host.sv
// Purpose: Host processor model, Avalon-MM master
// Assumes: Tasks are entered just after a rising edge
// Notes: Holds each request until waitrequest is sampled low
`timescale 1ns/1ns
module liugc_host
	import liugc_pkg::*;
(
	input wire logic mclk_i,
	input wire logic waitrequest_i,
	input wire logic [31:0] readdata_i,
	output logic [LIUGC_AW-1:0] address_o,
	output logic read_o,
	output logic write_o,
	output logic [31:0] writedata_o
);
	// Idle bus at time zero
	initial begin
		address_o = '0;
		read_o = 1'b0;
		write_o = 1'b0;
		writedata_o = '0;
	end
	// One access; an idle edge after release avoids double assignment
	task automatic acc(input logic [7:0] a, input logic rd, input logic [7:0] d,
		output logic [7:0] q);
		address_o <= a;
		read_o <= rd;
		write_o <= !rd;
		writedata_o <= {24'h000000, d};
		do @(posedge mclk_i); while (waitrequest_i !== 1'b0);
		q = readdata_i[7:0];
		read_o <= 1'b0;
		write_o <= 1'b0;
		@(posedge mclk_i);
	endtask
	// Clear bit held 33 cycles, past one microsecond at 25 MHz
	task automatic pulse_clr(input logic [7:0] v);
		logic [7:0] q;
		acc(LIUGC_CCTRL, 1'b0, v, q);
		repeat (30) @(posedge mclk_i);
		acc(LIUGC_CCTRL, 1'b0, 8'h00, q);
	endtask
endmodule

// File: testbench/liugc_sva.sv
// Purpose: Port assertions for the global configuration bank
// Assumes: One clock domain, reset active low
// Notes: The minimum-loss check watches channel 0 through a zero counter; the clear check covers all channels
`timescale 1ns/1ns
module liugc_sva
	import liugc_pkg::*;
(
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic [LIUGC_AW-1:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] readdata_o,
	input wire logic waitrequest_o,
	input wire logic in_circuit_test_n_i,
	input wire logic [LIUGC_CH-1:0] rx_bit_en_i,
	input wire logic [LIUGC_CH-1:0] rx_pos_in_i,
	input wire logic [LIUGC_CH-1:0] rx_neg_in_i,
	input wire logic [LIUGC_CH-1:0] receive_signal_loss_o,
	input wire logic master_rate_select_o,
	input wire logic outputs_float_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	logic [LIUGC_CH-1:0] marks;
	logic wsel;
	logic [12:0] zc;
	// Strobed marks and accepted writes to the clock register
	assign marks = rx_bit_en_i & (rx_pos_in_i | rx_neg_in_i);
	assign wsel = write_i && !waitrequest_o && address_i == LIUGC_CLK_LOS;
	// Run of zeros on channel 0; no saturation needed below 8191
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) zc <= '0;
		else if (rx_bit_en_i[0]) zc <= marks[0] ? 13'h0000 : zc + 13'h0001;
	end
	sequence acc_s;
		(read_i || write_i) && waitrequest_o;
	endsequence
	bus_ans_a: assert property (acc_s |=> !waitrequest_o) else $error("no answer");
	bus_one_a: assert property (!waitrequest_o |=> waitrequest_o) else $error("ready too long");
	bus_cause_a: assert property ($fell(waitrequest_o) |-> $past(read_i || write_i))
		else $error("ready without request");
	rd_hold_a: assert property ($changed(readdata_o) |-> !waitrequest_o && $past(read_i))
		else $error("read data moved");
	rd_upper_a: assert property (readdata_o[31:8] == 24'h000000) else $error("upper bits set");
	test_float_a: assert property (!in_circuit_test_n_i |=> outputs_float_o)
		else $error("test pin did not float");
	loss_clear_a: assert property ((receive_signal_loss_o & $past(marks, 2)) == '0)
		else $error("loss kept after mark");
	loss_min_a: assert property ($rose(receive_signal_loss_o[0]) |-> $past(zc) >= 13'h0020)
		else $error("loss too early");
	rate_cfg_a: assert property ($changed(master_rate_select_o) |->
		$past(wsel, 1) || $past(wsel, 2) || $past(wsel, 3)) else $error("rate moved alone");
endmodule
bind liugc_regs liugc_sva u_sva(.mclk_i(mclk_i), .nrst_i(nrst_i), .address_i(address_i),
	.read_i(read_i), .write_i(write_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
	.in_circuit_test_n_i(in_circuit_test_n_i), .rx_bit_en_i(rx_bit_en_i),
	.rx_pos_in_i(rx_pos_in_i), .rx_neg_in_i(rx_neg_in_i),
	.receive_signal_loss_o(receive_signal_loss_o),
	.master_rate_select_o(master_rate_select_o), .outputs_float_o(outputs_float_o));

// File: testbench/tb_liugc_regs.sv
// Purpose: Self-checking bench for the configuration bank
// Assumes: Expected values follow from the register layout
// Notes: Random values come from a fixed seed
`timescale 1ns/1ns
module tb_liugc_regs;
	import liugc_pkg::*;
	logic mclk_i = 0, nrst_i = 0, hm = 0, ictn = 1, txp = 0, tp = 0, rd, wr, wq, irq, rt, flt;
	logic [7:0] en = 0, pos = 0, neg = 0, line_code_violation = 0, addr, receive_positive_data, los, transmitter_on, term, v8;
	logic sh, sl;
	logic [7:0] receive_negative_data;
	logic [31:0] wd, rdat, v;
	logic [15:0] cnt[8], lat[8];
	int fail_count = 0, comparisons = 0, cyc = 0, seed = 32'hee13cba8;
	int thr[3] = '{32, 175, 4096};
	logic [7:0] cfg[3] = '{8'h04, 8'h0C, 8'h06};
	always #20 mclk_i = ~mclk_i;
	liugc_host u_host(.mclk_i(mclk_i), .waitrequest_i(wq), .readdata_i(rdat), .address_o(addr),
		.read_o(rd), .write_o(wr), .writedata_o(wd));
	liugc_regs u_dut(.mclk_i(mclk_i), .nrst_i(nrst_i), .address_i(addr), .read_i(rd),
		.write_i(wr), .writedata_i(wd), .readdata_o(rdat), .waitrequest_o(wq), .irq_o(irq),
		.host_mode_i(hm), .in_circuit_test_n_i(ictn), .transmitter_on_pin_i(txp),
		.receive_termination_pin_i(tp), .rx_bit_en_i(en), .rx_pos_in_i(pos), .rx_neg_in_i(neg),
		.line_code_violation_i(line_code_violation), .receive_positive_data_o(receive_positive_data),
		.receive_negative_data_o(receive_negative_data), .receive_signal_loss_o(los), .transmitter_on_o(transmitter_on),
		.receive_termination_select_o(term), .master_rate_select_o(rt),
		.synth_input_select_hi_o(sh), .synth_input_select_lo_o(sl), .outputs_float_o(flt));
	task automatic summarize();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		u_host.acc(a, 1'b0, d, q);
	endtask
	task automatic r(input logic [7:0] a, input logic [7:0] e, input string n);
		logic [7:0] q;
		u_host.acc(a, 1'b1, 8'h00, q);
		chk(n, e, q);
	endtask
	// Channel 0 bits, one strobe every other cycle
	task automatic bits(input int n, input logic [7:0] p);
		repeat (n) begin
			@(posedge mclk_i);
			en <= 8'h01;
			pos <= p;
			@(posedge mclk_i);
			en <= 8'h00;
		end
		repeat (3) @(posedge mclk_i);
	endtask
	// Latched bytes of selector codes 0 to 9, none codes read zero
	task automatic rdall();
		for (int s = 0; s < 10; s++) begin
			v = (s >= 1 && s <= 8) ? lat[s-1] : 0;
			w(LIUGC_VSEL, s[7:0]);
			w(LIUGC_CCTRL, 8'h00);
			r(LIUGC_CDATA, v[7:0], "count low");
			w(LIUGC_CCTRL, 8'h04);
			r(LIUGC_CDATA, v[15:8], "count high");
		end
	endtask
	// Hang guard, about six times the expected run
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			summarize();
		end
	end
	initial begin
		repeat (2) @(posedge mclk_i);
		nrst_i <= 1'b1;
		@(posedge mclk_i);
		foreach (cfg[i]) r(8'h80 + 8'(i + 1), 8'h00, "reset value");
		r(LIUGC_VSEL, 8'h00, "select reset");
		w(8'h00, 8'hFF);
		r(8'h00, 8'h00, "unmapped");
		repeat (4) begin
			v8 = 8'($random(seed));
			w(LIUGC_CLK_LOS, v8);
			r(LIUGC_CLK_LOS, v8 & 8'h3F, "clock reg");
			chk("rate", v8[3], rt);
			chk("synth select", v8[5:4], {sh, sl});
			chk("float", v8[0], flt);
			w(LIUGC_VSEL, v8);
			r(LIUGC_VSEL, v8 & 8'h0F, "select");
		end
		w(LIUGC_CLK_LOS, 8'h00);
		ictn <= 1'b0;
		repeat (2) @(posedge mclk_i);
		chk("float pin", 1, flt);
		ictn <= 1'b1;
		repeat (8) begin
			v = $random(seed);
			hm <= v[0];
			txp <= v[1];
			tp <= v[2];
			w(LIUGC_HOST_GLB, {6'h00, v[4:3]});
			w(LIUGC_TX_TERM, {v[6:5], 6'h00});
			w(LIUGC_CH_TRANSMITTER_ON, v[15:8]);
			w(LIUGC_CH_TERM, v[23:16]);
			// Outputs are registered after the last write; let them settle first
			repeat (2) @(posedge mclk_i);
			chk("tx on", v[6] ? v[15:8] : {8{v[0] ? v[3] : v[1]}}, transmitter_on);
			chk("term", v[5] ? {8{v[2]}} : {8{v[0] ? v[4] : v[2]}} & v[23:16], term);
		end
		for (int m = 0; m < 3; m++) begin
			w(LIUGC_IRQ_MASK, m == 1 ? 8'h00 : 8'h01);
			w(LIUGC_CLK_LOS, cfg[m]);
			bits(1, 8'h01);
			w(LIUGC_IRQ_STAT, 8'hFF);
			bits(thr[m] - 1, 8'h00);
			chk("loss early", 0, los[0]);
			bits(1, 8'h00);
			chk("loss", 1, los[0]);
			chk("irq", m != 1, irq);
			pos <= 8'hFF;
			neg <= 8'hFF;
			repeat (2) @(posedge mclk_i);
			// Only channel 0 is in loss; the others pass their data through
			chk("muted pos", 8'hFE, receive_positive_data);
			chk("muted neg", 8'hFE, receive_negative_data);
			pos <= 8'h00;
			neg <= 8'h00;
			w(LIUGC_IRQ_STAT, 8'h01);
			@(posedge mclk_i);
			chk("irq clear", 0, irq);
		end
		u_host.pulse_clr(8'h10);
		foreach (cnt[k]) cnt[k] = 16'({$random(seed)} % 300);
		cnt[0] = 16'h0100;
		cnt[7] = 16'h00FF;
		for (int i = 0; i < 300; i++) begin
			@(posedge mclk_i);
			foreach (cnt[k]) line_code_violation[k] <= i < cnt[k];
		end
		@(posedge mclk_i);
		line_code_violation <= 8'h00;
		w(LIUGC_CCTRL, 8'h08);
		lat = cnt;
		rdall();
		line_code_violation <= 8'hFF;
		repeat (5) @(posedge mclk_i);
		line_code_violation <= 8'h00;
		foreach (cnt[k]) cnt[k] += 16'h0005;
		w(LIUGC_VSEL, 8'h04);
		w(LIUGC_CCTRL, 8'h02);
		lat[3] = cnt[3];
		rdall();
		w(LIUGC_VSEL, 8'h02);
		u_host.pulse_clr(8'h01);
		cnt[1] = 16'h0000;
		w(LIUGC_CCTRL, 8'h08);
		lat = cnt;
		rdall();
		summarize();
	end
endmodule
